// [src/bus_xcvr_pkg.sv]
// Constants shared by the registered bus transceiver and its capture log.
// Assumes one 200 MHz clock; every pin except the asynchronous reset_n is sampled synchronously to it.
package bus_xcvr_pkg;
    localparam int SECTION_WIDTH = 9;   // Data bits per section
    localparam int SECTION_COUNT = 2;   // Independent sections
    localparam int BUS_WIDTH     = SECTION_WIDTH * SECTION_COUNT;
    localparam int LOG_DEPTH     = 8;   // Capture log words
    // Log word: four capture flags, then both registers of both sections
    localparam int LOG_FLAGS     = 2 * SECTION_COUNT;
    localparam int LOG_WIDTH     = LOG_FLAGS + 2 * BUS_WIDTH;
    localparam int CLK_PERIOD_NS = 5;   // ref_clk period
endpackage : bus_xcvr_pkg

// [src/registered_bus_transceiver.sv]
// Registered bus transceiver: sections that pass A to B and B to A,
// live or from edge-captured storage registers, plus a capture log FIFO.
// Assumes capture clocks, selects and enables are synchronous to ref_clk
// and that the bench resolves each pin from its output enable.
`timescale 1ns/10ps
`default_nettype none

// Small synchronous FIFO; head word and flags are registered.
module capture_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             reset_n,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int PW = $clog2(DEPTH);

    // Depth must be a power of two so pointers wrap by themselves
    initial
    begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
        begin
            $error("capture_fifo: DEPTH must be a power of two >= 2");
        end
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;      // Storage words
        logic [PW-1:0]               wrPtr;    // Next slot to fill
        logic [PW-1:0]               rdPtr;    // Slot of the head word
        logic [PW:0]                 count;    // Words held
        logic                        notEmpty; // Registered valid
        logic                        notFull;  // Registered ready
        logic [WIDTH-1:0]            head;     // Registered head word
    } fifo_state_t;

    fifo_state_t st_ff;   // Present state
    fifo_state_t nxt_st;  // Next state

    // Push and pop, then refresh the registered head and flags
    always_comb
    begin
        logic doPush;
        logic doPop;
        doPush = inValid && st_ff.notFull;
        doPop  = outReady && st_ff.notEmpty;
        nxt_st = st_ff;
        if (doPush)
        begin
            nxt_st.mem[st_ff.wrPtr] = inData;
            nxt_st.wrPtr = st_ff.wrPtr + 1'b1;
        end
        if (doPop)
        begin
            nxt_st.rdPtr = st_ff.rdPtr + 1'b1;
        end
        // Simultaneous push and pop leaves the count alone
        nxt_st.count    = st_ff.count + {{PW{1'b0}}, doPush}
                          - {{PW{1'b0}}, doPop};
        nxt_st.notEmpty = (nxt_st.count != '0);
        nxt_st.notFull  = (nxt_st.count != (PW+1)'(DEPTH));
        // Head follows the next read pointer, so a word pushed into an empty
        // log is visible one cycle later without a bypass path
        nxt_st.head     = nxt_st.mem[nxt_st.rdPtr];
    end

    // State register; empty after reset
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_ff <= '0;
            st_ff.notFull <= 1'b1;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Handshake flags and head leave straight from the state register
    assign inReady  = st_ff.notFull;
    assign outValid = st_ff.notEmpty;
    assign outData  = st_ff.head;
endmodule : capture_fifo

// Top: the transceiver sections and the capture log.
module registered_bus_transceiver #(
    parameter int SECTION_WIDTH = bus_xcvr_pkg::SECTION_WIDTH,
    parameter int SECTION_COUNT = bus_xcvr_pkg::SECTION_COUNT,
    parameter int LOG_DEPTH     = bus_xcvr_pkg::LOG_DEPTH
) (
    input  wire logic                                   ref_clk,
    input  wire logic                                   reset_n,
    input  wire logic                                   testModeActive,
    input  wire logic [SECTION_COUNT-1:0]               aToBCaptureClock,
    input  wire logic [SECTION_COUNT-1:0]               bToACaptureClock,
    input  wire logic [SECTION_COUNT-1:0]               aToBSourceSelect,
    input  wire logic [SECTION_COUNT-1:0]               bToASourceSelect,
    input  wire logic [SECTION_COUNT-1:0]               bSideDriveEnable,
    input  wire logic [SECTION_COUNT-1:0]               aSideDriveEnable_n,
    input  wire logic [SECTION_COUNT*SECTION_WIDTH-1:0] aPinIn,
    output logic [SECTION_COUNT*SECTION_WIDTH-1:0]      aPinOut,
    output logic [SECTION_COUNT*SECTION_WIDTH-1:0]      aPinOe,
    input  wire logic [SECTION_COUNT*SECTION_WIDTH-1:0] bPinIn,
    output logic [SECTION_COUNT*SECTION_WIDTH-1:0]      bPinOut,
    output logic [SECTION_COUNT*SECTION_WIDTH-1:0]      bPinOe,
    output logic                                        logValid,
    input  wire logic                                   logReady,
    output logic [2*SECTION_COUNT*SECTION_WIDTH+2*SECTION_COUNT-1:0] logData,
    output logic                                        logAccept,
    output logic                                        logOverflow
);
    localparam int BW = SECTION_COUNT * SECTION_WIDTH;        // Bus width
    localparam int LW = 2 * SECTION_COUNT + 2 * BW;           // Log width

    // Only the shapes the logic was sized for are served
    initial
    begin
        if (SECTION_WIDTH < 1 || SECTION_COUNT < 1 || LOG_DEPTH < 2)
        begin
            $error("registered_bus_transceiver: bad parameters");
        end
    end

    // All of the top's state except the log FIFO in one word: one comb fill, one register
    typedef struct packed {
        logic [SECTION_COUNT-1:0] abClkPrev;  // Last A-to-B clock level
        logic [SECTION_COUNT-1:0] baClkPrev;  // Last B-to-A clock level
        logic [BW-1:0]            abStore;    // A-to-B storage registers
        logic [BW-1:0]            baStore;    // B-to-A storage registers
        logic [BW-1:0]            aOut;       // A pin drive value
        logic [BW-1:0]            aOe;        // A pin drive enables
        logic [BW-1:0]            bOut;       // B pin drive value
        logic [BW-1:0]            bOe;        // B pin drive enables
        logic                     pushValid;  // Log word waiting
        logic [LW-1:0]            pushWord;   // Log word contents
        logic                     overflow;   // Log word dropped pulse
    } xcvr_state_t;

    xcvr_state_t st_ff;   // Present state
    xcvr_state_t nxt_st;  // Next state
    logic        fifoInReady;  // Log has room

    // Rising edge of a synchronously sampled capture clock
    function automatic logic risingEdge(input logic now, input logic prev);
        return now && !prev;
    endfunction : risingEdge

    // Datapath of every section, and the log word built from it
    always_comb
    begin
        logic [2*SECTION_COUNT-1:0] captured;
        logic                       abRise;
        logic                       baRise;
        logic                       bDrive;
        logic                       aDrive;
        int                         lo;
        captured = '0;
        abRise   = 1'b0;
        baRise   = 1'b0;
        bDrive   = 1'b0;
        aDrive   = 1'b0;
        lo       = 0;
        nxt_st   = st_ff;
        // Each section has its own clocks, selects and enables
        for (int s = 0; s < SECTION_COUNT; s++)
        begin
            lo = s * SECTION_WIDTH;   // Sections side by side
            // Only the test-mode level reaches this datapath; no scan port
            // exists here, so scan traffic in normal mode cannot upset it
            // Test mode freezes the storage registers
            abRise = risingEdge(aToBCaptureClock[s], st_ff.abClkPrev[s])
                     && !testModeActive;
            baRise = risingEdge(bToACaptureClock[s], st_ff.baClkPrev[s])
                     && !testModeActive;
            // Pin level is stored whoever drives it
            if (abRise)
            begin
                nxt_st.abStore[lo +: SECTION_WIDTH] =
                    aPinIn[lo +: SECTION_WIDTH];
            end
            if (baRise)
            begin
                nxt_st.baStore[lo +: SECTION_WIDTH] =
                    bPinIn[lo +: SECTION_WIDTH];
            end
            captured[2*s]   = abRise;
            captured[2*s+1] = baRise;

            // B side: enable active high, off in test mode
            bDrive = bSideDriveEnable[s] && !testModeActive;
            nxt_st.bOe[lo +: SECTION_WIDTH] = {SECTION_WIDTH{bDrive}};
            if (aToBSourceSelect[s])
            begin
                // Registered path
                nxt_st.bOut[lo +: SECTION_WIDTH] = st_ff.abStore[lo +: SECTION_WIDTH];
            end
            else
            begin
                // Transparent path
                nxt_st.bOut[lo +: SECTION_WIDTH] = aPinIn[lo +: SECTION_WIDTH];
            end

            // A side: enable active low, off in test mode
            aDrive = !aSideDriveEnable_n[s] && !testModeActive;
            nxt_st.aOe[lo +: SECTION_WIDTH] = {SECTION_WIDTH{aDrive}};
            if (bToASourceSelect[s])
            begin
                // Registered path
                nxt_st.aOut[lo +: SECTION_WIDTH] = st_ff.baStore[lo +: SECTION_WIDTH];
            end
            else
            begin
                // Transparent path
                nxt_st.aOut[lo +: SECTION_WIDTH] = bPinIn[lo +: SECTION_WIDTH];
            end
        end
        // Clock history always follows the pins, so leaving test mode
        // with a clock already high does not fake an edge
        nxt_st.abClkPrev = aToBCaptureClock;
        nxt_st.baClkPrev = bToACaptureClock;

        // Log hand-off: a waiting word goes when the FIFO has room
        nxt_st.overflow = 1'b0;
        if (st_ff.pushValid && fifoInReady)
        begin
            nxt_st.pushValid = 1'b0;
        end
        if (captured != '0)
        begin
            // A stuck word is replaced; the loss is flagged for one cycle
            // because capture must never wait on the log
            // Under a long stall the log therefore keeps the oldest words
            nxt_st.overflow  = st_ff.pushValid && !fifoInReady;
            nxt_st.pushValid = 1'b1;
            nxt_st.pushWord  = {captured, nxt_st.baStore, nxt_st.abStore};
        end
    end

    // State register; buses float and storage is clear after reset
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Capture log; a low logReady stalls it until it fills
    // Its head, valid and room flag are flops, so the log outputs are
    // registered like the pins
    capture_fifo #(
        .WIDTH (LW),
        .DEPTH (LOG_DEPTH)
    ) logFifo (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .inValid  (st_ff.pushValid),
        .inReady  (fifoInReady),
        .inData   (st_ff.pushWord),
        .outValid (logValid),
        .outReady (logReady),
        .outData  (logData)
    );

    // Pin drive straight from the state register
    // Value and enable leave together, so a pin never shows a stale value
    assign aPinOut     = st_ff.aOut;
    assign aPinOe      = st_ff.aOe;
    assign bPinOut     = st_ff.bOut;
    assign bPinOe      = st_ff.bOe;
    assign logAccept   = fifoInReady;
    assign logOverflow = st_ff.overflow;
endmodule : registered_bus_transceiver

`default_nettype wire

// [tb/xcvr_props.sv]
// Port-level checker for the registered bus transceiver.
// Assumes the default two-section build; bound into every instance.
`timescale 1ns/10ps
`default_nettype none
module xcvr_props (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        testModeActive,
    input  wire logic [1:0]  aToBCaptureClock,
    input  wire logic [1:0]  bToACaptureClock,
    input  wire logic [1:0]  aToBSourceSelect,
    input  wire logic [1:0]  bToASourceSelect,
    input  wire logic [1:0]  bSideDriveEnable,
    input  wire logic [1:0]  aSideDriveEnable_n,
    input  wire logic [17:0] aPinIn,
    input  wire logic [17:0] aPinOut,
    input  wire logic [17:0] aPinOe,
    input  wire logic [17:0] bPinIn,
    input  wire logic [17:0] bPinOut,
    input  wire logic [17:0] bPinOe,
    input  wire logic        logValid,
    input  wire logic        logReady,
    input  wire logic [39:0] logData,
    input  wire logic        logOverflow
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // Transparent paths answer one cycle after the pins are sampled
    AST_B_LIVE: assert property (
        bSideDriveEnable[0] && !aToBSourceSelect[0] && !testModeActive
        |=> bPinOe[8:0] == 9'h1ff && bPinOut[8:0] == $past(aPinIn[8:0]))
        else $error("live A data missing on B");
    AST_A_LIVE: assert property (
        !aSideDriveEnable_n[1] && !bToASourceSelect[1] && !testModeActive
        |=> aPinOe[17:9] == 9'h1ff && aPinOut[17:9] == $past(bPinIn[17:9]))
        else $error("live B data missing on A");
    AST_B_OFF: assert property (
        !bSideDriveEnable[1] |=> bPinOe[17:9] == 9'h000)
        else $error("B driven while disabled");
    AST_A_OFF: assert property (
        aSideDriveEnable_n[0] |=> aPinOe[8:0] == 9'h000)
        else $error("A driven while disabled");
    AST_TEST: assert property (
        testModeActive |=> aPinOe == 18'h0 && bPinOe == 18'h0)
        else $error("pins driven in test mode");
    // Capture ignores the enable; the store shows two cycles after its edge
    AST_AB_STORE: assert property (
        $rose(aToBCaptureClock[0]) && !testModeActive
        ##1 (aToBSourceSelect[0] && bSideDriveEnable[0] && !testModeActive)
        |=> bPinOut[8:0] == $past(aPinIn[8:0], 2))
        else $error("stored A data wrong on B");
    AST_BA_STORE: assert property (
        $rose(bToACaptureClock[1]) && !testModeActive
        ##1 (bToASourceSelect[1] && !aSideDriveEnable_n[1] && !testModeActive)
        |=> aPinOut[17:9] == $past(bPinIn[17:9], 2))
        else $error("stored B data wrong on A");
    AST_AB_HOLD: assert property (
        (!aToBCaptureClock[1] && aToBSourceSelect[1] && bSideDriveEnable[1]
        && !testModeActive)[*2] |=> $stable(bPinOut[17:9]))
        else $error("store changed without a clock edge");
    AST_LOG_HELD: assert property ( // Log head waits for the consumer
        logValid && !logReady |=> logValid && $stable(logData))
        else $error("log head dropped while stalled");
    CV_BOTH: cover property (aToBSourceSelect[0] && bToASourceSelect[0]
        && bSideDriveEnable[0] && !aSideDriveEnable_n[0]);
    CV_TEST: cover property (testModeActive && $rose(aToBCaptureClock[0]));
    CV_OVF: cover property (logOverflow);
endmodule : xcvr_props

bind registered_bus_transceiver xcvr_props i_props (.ref_clk, .reset_n, .testModeActive,
    .aToBCaptureClock, .bToACaptureClock, .aToBSourceSelect, .bToASourceSelect,
    .bSideDriveEnable, .aSideDriveEnable_n, .aPinIn, .aPinOut, .aPinOe, .bPinIn,
    .bPinOut, .bPinOe, .logValid, .logReady, .logData, .logOverflow);
`default_nettype wire

// [tb/bus_partner.sv]
// Board drivers on both data buses.
// Assumes per-bit drive enables; a bit the device leaves free carries board data.
`timescale 1ns/10ps
`default_nettype none
module bus_partner (
    input  wire logic [17:0] aPinOut,
    input  wire logic [17:0] aPinOe,
    input  wire logic [17:0] bPinOut,
    input  wire logic [17:0] bPinOe,
    input  wire logic [17:0] aBoard,
    input  wire logic [17:0] bBoard,
    output logic [17:0]      aPinIn,
    output logic [17:0]      bPinIn
);
    // Board yields each bit the device drives, so there is never contention
    assign aPinIn = (aPinOut & aPinOe) | (aBoard & ~aPinOe);
    assign bPinIn = (bPinOut & bPinOe) | (bBoard & ~bPinOe);
endmodule : bus_partner
`default_nettype wire

// [tb/test_registered_bus_transceiver.sv]
// Self-checking bench: cycle model of both sections and of the capture log.
// Assumes bus_partner resolves the pins and the checker is bound.
`timescale 1ns/10ps
`default_nettype none
module test_registered_bus_transceiver;
    logic ref_clk = 0, reset_n = 0, testModeActive = 0, logReady = 1;
    logic [1:0] aToBCaptureClock = 0, bToACaptureClock = 0, aToBSourceSelect = 0;
    logic [1:0] bToASourceSelect = 0, bSideDriveEnable = 0, aSideDriveEnable_n = 2'h3;
    logic [17:0] aBoard = 0, bBoard = 0, aPinIn, bPinIn, aPinOut, aPinOe, bPinOut, bPinOe;
    logic [17:0] eAOut, eAOe, eBOut, eBOe;
    logic        logValid, logAccept, logOverflow;
    logic [39:0] logData, logQ[$];
    logic [8:0]  abSt[2], baSt[2];
    logic [1:0]  prevAb, prevBa;
    int          miscompares = 0, checksDone = 0, cycles = 0, ovfSeen = 0;
    registered_bus_transceiver i_dut (.ref_clk, .reset_n, .testModeActive,
        .aToBCaptureClock, .bToACaptureClock, .aToBSourceSelect, .bToASourceSelect,
        .bSideDriveEnable, .aSideDriveEnable_n, .aPinIn, .aPinOut, .aPinOe, .bPinIn,
        .bPinOut, .bPinOe, .logValid, .logReady, .logData, .logAccept, .logOverflow);
    bus_partner i_board (.aPinOut, .aPinOe, .bPinOut, .bPinOe, .aBoard, .bBoard,
        .aPinIn, .bPinIn);
    initial
        forever #2.5 ref_clk = ~ref_clk;
    task automatic check(string what, logic [39:0] seen, logic [39:0] exp);
        checksDone++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic reportAndStop();
        $display("checks %0d mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : reportAndStop
    // Model: compare last edge's prediction, then predict from this edge
    always @(posedge ref_clk)
    begin
        logic [3:0] fl;
        if (++cycles > 2000)
        begin
            miscompares++;
            reportAndStop();
        end
        else if (!reset_n)
        begin
            abSt = '{default: 9'h0};
            baSt = '{default: 9'h0};
            {prevAb, prevBa, eAOut, eAOe, eBOut, eBOe} = '0;
            logQ.delete();
        end
        else
        begin
            check("aOe", 40'(aPinOe), 40'(eAOe));
            check("bOe", 40'(bPinOe), 40'(eBOe));
            check("aOut", 40'(aPinOut & aPinOe), 40'(eAOut & eAOe));
            check("bOut", 40'(bPinOut & bPinOe), 40'(eBOut & eBOe));
            ovfSeen += logOverflow;
            if (logValid && logReady)
                check("log", logData, logQ.size() ? logQ.pop_front() : 40'h0);
            fl = 4'h0;
            for (int s = 0; s < 2; s++)
            begin
                eBOe[9*s+:9] = {9{bSideDriveEnable[s] & ~testModeActive}};
                eAOe[9*s+:9] = {9{~aSideDriveEnable_n[s] & ~testModeActive}};
                eBOut[9*s+:9] = aToBSourceSelect[s] ? abSt[s] : aPinIn[9*s+:9];
                eAOut[9*s+:9] = bToASourceSelect[s] ? baSt[s] : bPinIn[9*s+:9];
                // Captures take the resolved pin, whoever drives it
                fl[2*s] = !testModeActive && aToBCaptureClock[s] && !prevAb[s];
                fl[2*s+1] = !testModeActive && bToACaptureClock[s] && !prevBa[s];
                if (fl[2*s])
                    abSt[s] = aPinIn[9*s+:9];
                if (fl[2*s+1])
                    baSt[s] = bPinIn[9*s+:9];
            end
            prevAb = aToBCaptureClock;
            prevBa = bToACaptureClock;
            // A full log plus its waiting word holds nine; newer words replace the waiting one
            if (fl != 0 && !logReady && logQ.size() == 9)
                logQ[8] = {fl, baSt[1], baSt[0], abSt[1], abSt[0]};
            else if (fl != 0)
                logQ.push_back({fl, baSt[1], baSt[0], abSt[1], abSt[0]});
        end
    end
    task automatic step(int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step
    task automatic doReset();
        reset_n = 0;
        step(10);
        reset_n = 1;
    endtask : doReset
    task automatic randomRun(int n);
        for (int i = 0; i < n; i++)
        begin
            step(1);
            aBoard = 18'($urandom());
            bBoard = 18'($urandom());
            {aToBSourceSelect, bToASourceSelect, bSideDriveEnable, aSideDriveEnable_n} = 8'($urandom());
            testModeActive = ($urandom_range(7) == 0);
            // One clock moves per four cycles, so loads stay staggered
            if (i % 4 == 0)
                {aToBCaptureClock, bToACaptureClock} ^= 4'(1 << $urandom_range(3));
        end
    endtask : randomRun
    initial
    begin
        void'($urandom(32'h8a220863));
        doReset();
        randomRun(400);
        // Paired loads through the driven bus, then both stores shown at once
        for (int m = 0; m < 2; m++)
        begin
            step(2);
            {testModeActive, aToBCaptureClock, bToACaptureClock} = '0;
            {aToBSourceSelect, bToASourceSelect} = '0;
            bSideDriveEnable = m ? 2'h0 : 2'h3;
            aSideDriveEnable_n = m ? 2'h0 : 2'h3;
            aBoard = 18'($urandom());
            bBoard = 18'($urandom());
            step(2);
            {aToBCaptureClock, bToACaptureClock} = 4'hf; // Selects low: edges may coincide
            step(2);
            {aToBSourceSelect, bToASourceSelect, bSideDriveEnable, aSideDriveEnable_n} = 8'hfc;
            step(3);
        end
        // Stall the log until it refuses, overflow once, then drain it
        {aToBCaptureClock, bToACaptureClock} = '0;
        step(4);
        logReady = 0;
        for (int i = 0; i < 10; i++)
        begin
            aBoard = 18'($urandom());
            aToBCaptureClock[0] = 1;
            step(2);
            aToBCaptureClock[0] = 0;
            step(2);
        end
        check("logAccept", 40'(logAccept), 40'h0);
        check("overflows", 40'(ovfSeen), 40'h1);
        logReady = 1;
        step(14);
        check("logValid", 40'(logValid), 40'h0);
        check("logLeft", 40'(logQ.size()), 40'h0);
        doReset();
        randomRun(100);
        reportAndStop();
    end
endmodule : test_registered_bus_transceiver
`default_nettype wire
